// ===== inc/amp_diag_pkg.sv
// package of constants for the amplifier diagnostic readback block
// How it works
// - address bit 0 picks write or read
// - write is address, two instruction bytes, stop
// - read returns status first then second byte
// - first instruction bit 6 enables diagnostics
// - first status bit 7 flags thermal warning
// - first status bit 6 flags cycle terminated
// - second instruction bit 0 picks current threshold
// - first status bit 5 channel one current
// - second status bit 5 channel two current
// - status bit 4 turn-on or permanent source
// - status bit 3 flags shorted load
// - status bit 2 open load or offset
// - status bit 1 flags short to supply
// - status bit 0 flags short to ground
// - second status bit 7 offset detection active
// - second status bit 6 current sensor active
// - second instruction bit 4 leaves standby
// - read after offset test stops the test
package amp_diag_pkg;
  // seven-bit slave address, low two bits come from straps
  localparam logic [4:0] ADDR_HI = 5'h1a;
  // address byte direction bit
  localparam int DIR_BIT = 0;
  // first instruction byte fields
  localparam int IB1_DIAG_EN = 6;
  localparam int IB1_OFFS_EN = 5;
  localparam int IB1_GAIN_LO = 4;
  localparam int IB1_UNMUTE = 2;
  localparam int IB1_CLIP_SEL = 0;
  // second instruction byte fields
  localparam int IB2_RUN = 4;
  localparam int IB2_LINE_DRV = 3;
  localparam int IB2_CUR_EN = 2;
  localparam int IB2_HI_EFF = 1;
  localparam int IB2_THR_LOW = 0;
  // status byte fields
  localparam int DS_THERM = 7;
  localparam int DS_DONE = 6;
  localparam int DS_OFFS_ACT = 7;
  localparam int DS_CUR_ACT = 6;
  localparam int DS_AC_OPEN = 5;
  localparam int DS_PERM = 4;
  localparam int DS_SHORT_LOAD = 3;
  localparam int DS_OPEN_OFFS = 2;
  localparam int DS_SHORT_VCC = 1;
  localparam int DS_SHORT_GND = 0;
  // reset values of the instruction bytes
  localparam logic [7:0] IB1_RST = 8'h00;
  localparam logic [7:0] IB2_RST = 8'h00;
endpackage : amp_diag_pkg

// ===== design/amp_diag_status_readback.sv
// two-wire slave holding instruction bytes and serving diagnostic status bytes
module amp_diag_status_readback
  import amp_diag_pkg::*;
(
  // system clock and reset
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  // address straps
  input wire logic [1:0] addr_sel_in,
  // two-wire link, scl is the link clock
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_out,
  // analogue front end results, system domain
  input wire logic therm_warn_in,
  input wire logic cycle_done_in,
  input wire logic [1:0] ac_open_in,
  input wire logic [1:0] perm_src_in,
  input wire logic [1:0] short_load_in,
  input wire logic [1:0] open_offs_in,
  input wire logic [1:0] short_vcc_in,
  input wire logic [1:0] short_gnd_in,
  // controls to the amplifier
  output logic diag_en_out,
  output logic offs_en_out,
  output logic gain_low_out,
  output logic unmute_out,
  output logic clip_sel_out,
  output logic run_out,
  output logic line_drv_out,
  output logic cur_en_out,
  output logic hi_eff_out,
  output logic thr_low_out,
  // one-cycle pulse when a status read finishes
  output logic read_done_out
);
  // link states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_ADDR = 5'b00010,
    ST_WR = 5'b00100,
    ST_RD = 5'b01000,
    ST_HOLD = 5'b10000
  } link_st_t;

  // link-domain registers
  // the link clock has no reset, so its registers other than sh_r, ds1_l_r and ds2_l_r power up at known values
  link_st_t st_r = ST_IDLE;
  logic [7:0] sh_r;        // shift register
  logic [3:0] cnt_r = 4'h0;       // bit counter, 8 is ack slot
  logic byte_idx_r = 1'b0;        // which data byte
  logic ack_r = 1'b0;             // drive low at ack
  logic drv_r = 1'b0;             // drive data bit
  logic [7:0] ib1_l_r = IB1_RST;  // first instruction byte, link side
  logic [7:0] ib2_l_r = IB2_RST;  // second instruction byte, link side
  logic wr_tog_r = 1'b0;          // toggles on a completed write
  logic rd_tog_r = 1'b0;          // toggles on a completed read
  logic got2_r = 1'b0;            // second instruction byte received
  logic rd_any_r = 1'b0;          // a status byte was sent
  // start and stop detection, asynchronous to scl
  logic start_tog_r = 1'b0;
  logic stop_tog_r = 1'b0;
  logic start_seen_r = 1'b0;      // start toggle as last seen on scl
  logic stop_l_r = 1'b0;          // stop toggle as last seen on scl

  // start: sda falls while scl high; flip a toggle on the sda edge
  always_ff @(negedge sda_in) begin
    if (scl_in) begin
      start_tog_r <= ~start_tog_r;
    end
  end
  // stop: sda rises while scl high
  always_ff @(posedge sda_in) begin
    if (scl_in) begin
      stop_tog_r <= ~stop_tog_r;
    end
  end

  // status bytes assembled in system domain, captured at the start of every frame
  logic [7:0] ds1_r;
  logic [7:0] ds2_r;
  logic [7:0] ds1_l_r;
  logic [7:0] ds2_l_r;

  // link receive on scl rising edge
  always_ff @(posedge scl_in) begin
    start_seen_r <= start_tog_r;
    stop_l_r <= stop_tog_r;
    // the toggle settles while scl is high, well before this edge
    if (start_seen_r != start_tog_r) begin
      // fresh start: the first bit of the address is sampled now
      st_r <= ST_ADDR;
      sh_r <= {7'h00, sda_in};
      cnt_r <= 4'h1;
      byte_idx_r <= 1'b0;
      got2_r <= 1'b0;
      rd_any_r <= 1'b0;
      ds1_l_r <= ds1_r;
      ds2_l_r <= ds2_r;
    end else begin
      case (st_r)
        ST_ADDR: begin
          if (cnt_r == 4'h8) begin
            // ack slot over; sh_r holds address byte
            cnt_r <= 4'h0;
            if (sh_r[7:1] != {ADDR_HI, addr_sel_in}) begin
              st_r <= ST_IDLE;
            end else if (sh_r[DIR_BIT]) begin
              st_r <= ST_RD;
            end else begin
              st_r <= ST_WR;
            end
          end else begin
            sh_r <= {sh_r[6:0], sda_in};
            cnt_r <= cnt_r + 4'h1;
          end
        end
        ST_WR: begin
          if (cnt_r == 4'h8) begin
            cnt_r <= 4'h0;
            byte_idx_r <= ~byte_idx_r;
            if (byte_idx_r) begin
              st_r <= ST_HOLD;
            end
          end else begin
            sh_r <= {sh_r[6:0], sda_in};
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r == 4'h7) begin
              // latch full byte as first or second instruction
              if (!byte_idx_r) begin
                ib1_l_r <= {sh_r[6:0], sda_in};
              end else begin
                ib2_l_r <= {sh_r[6:0], sda_in};
                got2_r <= 1'b1;
              end
            end
          end
        end
        ST_RD: begin
          if (cnt_r == 4'h8) begin
            // host ack bit: nack or second byte ends the read
            cnt_r <= 4'h0;
            byte_idx_r <= ~byte_idx_r;
            rd_any_r <= 1'b1;
            if (sda_in || byte_idx_r) begin
              st_r <= ST_HOLD;
            end
          end else begin
            cnt_r <= cnt_r + 4'h1;
          end
        end
        default: begin
          // idle or hold until next start
          cnt_r <= 4'h0;
        end
      endcase
    end
  end

  // stop closes the frame; it is seen on the first scl rise after stop
  always_ff @(posedge scl_in) begin
    if (stop_l_r != stop_tog_r) begin
      if (got2_r) begin
        wr_tog_r <= ~wr_tog_r;
      end
      if (rd_any_r) begin
        rd_tog_r <= ~rd_tog_r;
      end
    end
  end

  // link drive on scl falling edge
  always_ff @(negedge scl_in) begin
    ack_r <= 1'b0;
    drv_r <= 1'b0;
    if ((st_r == ST_ADDR && cnt_r == 4'h8 && sh_r[7:1] == {ADDR_HI, addr_sel_in}) ||
        (st_r == ST_WR && cnt_r == 4'h8)) begin
      ack_r <= 1'b1;
    end else if (st_r == ST_RD && cnt_r < 4'h8) begin
      // msb first; release sda on ones
      drv_r <= ~(byte_idx_r ? ds2_l_r[3'h7 - cnt_r[2:0]]
                            : ds1_l_r[3'h7 - cnt_r[2:0]]);
    end
  end

  // system domain: three-stage sync of event toggles and of the data pin enable
  logic [2:0] wr_s_r;
  logic [2:0] rd_s_r;
  logic [2:0] sda_oe_s_r;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      wr_s_r <= 3'h0;
      rd_s_r <= 3'h0;
      sda_oe_s_r <= 3'h0;
    end else begin
      wr_s_r <= {wr_s_r[1:0], wr_tog_r};
      rd_s_r <= {rd_s_r[1:0], rd_tog_r};
      sda_oe_s_r <= {sda_oe_s_r[1:0], ack_r | drv_r};
    end
  end
  logic wr_evt;
  logic rd_evt;
  assign wr_evt = wr_s_r[2] != wr_s_r[1];
  assign rd_evt = rd_s_r[2] != rd_s_r[1];

  // instruction bytes take effect after a complete write
  logic [7:0] ib1_r;
  logic [7:0] ib2_r;
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      ib1_r <= IB1_RST;
      ib2_r <= IB2_RST;
    end else if (wr_evt) begin
      ib1_r <= ib1_l_r;
      ib2_r <= ib2_l_r;
    end else if (rd_evt) begin
      ib1_r[IB1_OFFS_EN] <= 1'b0;
    end
  end

  // control outputs registered
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      diag_en_out <= 1'b0;
      offs_en_out <= 1'b0;
      gain_low_out <= 1'b0;
      unmute_out <= 1'b0;
      clip_sel_out <= 1'b0;
      run_out <= 1'b0;
      line_drv_out <= 1'b0;
      cur_en_out <= 1'b0;
      hi_eff_out <= 1'b0;
      thr_low_out <= 1'b0;
      read_done_out <= 1'b0;
      sda_out <= 1'b0;
      sda_oe_out <= 1'b0;
    end else begin
      diag_en_out <= ib1_r[IB1_DIAG_EN];
      offs_en_out <= ib1_r[IB1_OFFS_EN];
      gain_low_out <= ib1_r[IB1_GAIN_LO];
      unmute_out <= ib1_r[IB1_UNMUTE];
      clip_sel_out <= ib1_r[IB1_CLIP_SEL];
      run_out <= ib2_r[IB2_RUN];
      line_drv_out <= ib2_r[IB2_LINE_DRV];
      cur_en_out <= ib2_r[IB2_CUR_EN];
      hi_eff_out <= ib2_r[IB2_HI_EFF];
      thr_low_out <= ib2_r[IB2_THR_LOW];
      read_done_out <= rd_evt;
      sda_out <= 1'b0;
      sda_oe_out <= sda_oe_s_r[2] & sda_oe_s_r[1];
    end
  end

  // status bytes from front-end results; front end applies the threshold
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in) begin
      ds1_r <= 8'h00;
      ds2_r <= 8'h00;
    end else begin
      ds1_r[DS_THERM] <= therm_warn_in;
      ds1_r[DS_DONE] <= cycle_done_in & ib1_r[IB1_DIAG_EN];
      ds2_r[DS_OFFS_ACT] <= ib1_r[IB1_OFFS_EN];
      ds2_r[DS_CUR_ACT] <= ib2_r[IB2_CUR_EN];
      ds1_r[DS_AC_OPEN] <= ac_open_in[0];
      ds2_r[DS_AC_OPEN] <= ac_open_in[1];
      ds1_r[DS_PERM] <= perm_src_in[0];
      ds2_r[DS_PERM] <= perm_src_in[1];
      ds1_r[DS_SHORT_LOAD] <= short_load_in[0];
      ds2_r[DS_SHORT_LOAD] <= short_load_in[1];
      ds1_r[DS_OPEN_OFFS] <= open_offs_in[0];
      ds2_r[DS_OPEN_OFFS] <= open_offs_in[1];
      ds1_r[DS_SHORT_VCC] <= short_vcc_in[0];
      ds2_r[DS_SHORT_VCC] <= short_vcc_in[1];
      ds1_r[DS_SHORT_GND] <= short_gnd_in[0];
      ds2_r[DS_SHORT_GND] <= short_gnd_in[1];
    end
  end
endmodule : amp_diag_status_readback

// ===== testbench/amp_diag_checker_sva.sv
// port checker for the diagnostic readback block
module amp_diag_checker (
  // clock, reset, link clock
  input wire logic sys_clk_in,
  input wire logic rst_b_in,
  input wire logic scl_in,
  // watched outputs
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic diag_en_out,
  input wire logic offs_en_out,
  input wire logic run_out,
  input wire logic thr_low_out,
  input wire logic read_done_out
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_b_in);
  logic [1:0] scl_r; // link clock seen in the system domain
  logic [7:0] idle_r; // cycles since the link clock last moved
  // resample the link clock
  always_ff @(posedge sys_clk_in) begin
    scl_r <= {scl_r[0], scl_in};
  end
  // saturating quiet-link counter
  always_ff @(posedge sys_clk_in) begin
    if (!rst_b_in || (scl_r[1] != scl_r[0])) begin
      idle_r <= 8'h00;
    end else if (idle_r != 8'hff) begin
      idle_r <= idle_r + 8'h01;
    end
  end
  a_rst_idle: assert property ($rose(rst_b_in) |-> !diag_en_out && !run_out && !sda_oe_out)
    else $error("outputs not idle after reset");
  a_sda_pull: assert property (sda_out == 1'b0)
    else $error("data pin driven high");
  a_done_pulse: assert property (read_done_out |=> !read_done_out)
    else $error("read done longer than one cycle");
  a_offs_stop: assert property (read_done_out |-> ##[0:6] !offs_en_out)
    else $error("offset test not stopped by read");
  a_read_keep: assert property (read_done_out |-> $stable(diag_en_out) && $stable(run_out))
    else $error("read changed instruction outputs");
  a_thr_keep: assert property ($rose(read_done_out) |=> $stable(thr_low_out))
    else $error("read changed threshold select");
  a_idle_hold: assert property (idle_r > 8'd40 |-> $stable(run_out) && $stable(offs_en_out))
    else $error("output moved with link quiet");
  a_idle_free: assert property (idle_r > 8'd40 |-> !sda_oe_out)
    else $error("data pin held with link quiet");
  c_read: cover property (read_done_out);
  c_offs: cover property ($rose(offs_en_out));
  c_run: cover property ($rose(run_out));
endmodule : amp_diag_checker
bind amp_diag_status_readback amp_diag_checker u_chk (.*);

// ===== testbench/amp_host_model.sv
// two-wire host model that writes instructions and reads status
module amp_host_model (
  // link pins
  input wire logic sda_in,
  output logic scl_out,
  output logic pull_out,
  // bytes read back
  output logic [7:0] rx_byte_out,
  output logic rx_stb_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // idle: clock high, data released
  initial begin
    scl_out = 1'b1;
    pull_out = 1'b0;
    rx_byte_out = 8'h00;
    rx_stb_out = 1'b0;
  end
  // long low phase lets the slave answer through its synchroniser
  task automatic bit_io(input logic b, output logic s);
    pull_out = !b;
    #60 scl_out = 1'b1;
    s = sda_in;
    #7.5 scl_out = 1'b0;
    #7.5;
  endtask : bit_io
  // start, address, two bytes msb first, stop, closing clock pulse
  task automatic xfer(input logic [7:0] adr, input logic [15:0] wd);
    logic s;
    logic [7:0] r;
    pull_out = 1'b1;
    #30 scl_out = 1'b0;
    for (int i = 7; i >= 0; i--) bit_io(adr[i], s);
    bit_io(1'b1, s);
    for (int k = 0; k < 2; k++) begin
      for (int i = 7; i >= 0; i--) begin
        bit_io(adr[0] | wd[8*(1-k)+i], s);
        r[i] = s;
      end
      bit_io(adr[0] ? (k == 1) : 1'b1, s);
      if (adr[0]) begin
        rx_byte_out = r;
        rx_stb_out = 1'b1;
        #1 rx_stb_out = 1'b0;
      end
    end
    pull_out = 1'b1;
    #60 scl_out = 1'b1;
    #30 pull_out = 1'b0;
    #30 scl_out = 1'b0;
    #60 scl_out = 1'b1;
    #30;
  endtask : xfer
endmodule : amp_host_model

// ===== testbench/amp_diag_status_readback_tb_top.sv
// self-checking bench for the diagnostic readback block
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL t=%0t got=%h exp=%h", $time, g, e); end end
module amp_diag_status_readback_tb_top;
  import amp_diag_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic sys_clk_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic [1:0] addr_sel_in = 2'h0;
  logic therm = 1'b0;
  logic done = 1'b0;
  logic [1:0] ac = 2'h0, pm = 2'h0, sl = 2'h0, oo = 2'h0, sv = 2'h0, sg = 2'h0;
  logic scl, pull, sda_o, sda_oe, read_done, rx_stb;
  logic chk_stb = 1'b0;
  logic [7:0] rx_byte, ib1 = IB1_RST, ib2 = IB2_RST;
  logic [9:0] got, ex;
  logic [9:0] exp_q[$]; // expected results, oldest first
  logic [31:0] seed = 32'h232d3d55, r;
  int err_count = 0, check_count = 0;
  wire [9:0] ctl; // instruction outputs in a row
  wire sda = !((sda_oe && !sda_o) || pull); // pulled-up open-drain line
  always #5 sys_clk_in = !sys_clk_in;
  amp_diag_status_readback u_dut (.sys_clk_in(sys_clk_in), .rst_b_in(rst_b_in),
    .addr_sel_in(addr_sel_in), .scl_in(scl), .sda_in(sda), .sda_out(sda_o),
    .sda_oe_out(sda_oe), .therm_warn_in(therm), .cycle_done_in(done), .ac_open_in(ac),
    .perm_src_in(pm), .short_load_in(sl), .open_offs_in(oo), .short_vcc_in(sv),
    .short_gnd_in(sg), .diag_en_out(ctl[9]), .offs_en_out(ctl[8]), .gain_low_out(ctl[7]),
    .unmute_out(ctl[6]), .clip_sel_out(ctl[5]), .run_out(ctl[4]), .line_drv_out(ctl[3]),
    .cur_en_out(ctl[2]), .hi_eff_out(ctl[1]), .thr_low_out(ctl[0]),
    .read_done_out(read_done));
  amp_host_model u_host (.sda_in(sda), .scl_out(scl), .pull_out(pull),
    .rx_byte_out(rx_byte), .rx_stb_out(rx_stb));
  // compare each status byte or output snapshot with the oldest note
  always @(posedge rx_stb or posedge chk_stb) begin
    got = rx_stb ? {2'b00, rx_byte} : ctl;
    ex = exp_q.pop_front();
    `CHK(got, ex)
  end
  // note the expected instruction outputs and ask for a snapshot
  task automatic ctl_chk();
    exp_q.push_back({ib1[IB1_DIAG_EN], ib1[IB1_OFFS_EN], ib1[IB1_GAIN_LO], ib1[IB1_UNMUTE],
      ib1[IB1_CLIP_SEL], ib2[IB2_RUN], ib2[IB2_LINE_DRV], ib2[IB2_CUR_EN], ib2[IB2_HI_EFF],
      ib2[IB2_THR_LOW]});
    chk_stb = 1'b1;
    #1 chk_stb = 1'b0;
  endtask : ctl_chk
  // write both instruction bytes; a foreign address leaves them alone
  task automatic wr(input logic [1:0] a, input logic [7:0] b1, input logic [7:0] b2);
    u_host.xfer({ADDR_HI, a, 1'b0}, {b1, b2});
    repeat (8) @(negedge sys_clk_in);
    if (a === addr_sel_in) begin
      ib1 = b1;
      ib2 = b2;
    end
    ctl_chk();
  endtask : wr
  // read both status bytes; reading stops the offset test
  task automatic rd();
    exp_q.push_back({2'b00, therm, done & ib1[IB1_DIAG_EN], ac[0], pm[0], sl[0], oo[0],
      sv[0], sg[0]});
    exp_q.push_back({2'b00, ib1[IB1_OFFS_EN], ib2[IB2_CUR_EN], ac[1], pm[1], sl[1], oo[1],
      sv[1], sg[1]});
    u_host.xfer({ADDR_HI, addr_sel_in, 1'b1}, 16'h0000);
    repeat (8) @(negedge sys_clk_in);
    ib1[IB1_OFFS_EN] = 1'b0;
    ctl_chk();
  endtask : rd
  // print counts and verdict, then stop
  task automatic end_sim();
    $display("checks=%0d errors=%0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  // main sequence
  initial begin
    repeat (12) @(negedge sys_clk_in);
    rst_b_in = 1'b1;
    wr(addr_sel_in, ib1 & 8'h8f, ib2 | 8'h12);
    for (int n = 0; n < 6; n++) begin
      r = $random(seed);
      {addr_sel_in, therm, done, ac, pm, sl, oo, sv, sg} = r[15:0];
      wr(addr_sel_in, r[23:16] & 8'h75, r[31:24] & 8'h1f);
      rd();
    end
    wr(~addr_sel_in, 8'h75, 8'h1f);
    wr(addr_sel_in, ib1 | 8'h64, ib2 | 8'h10);
    done = 1'b1;
    rd();
    wr(addr_sel_in, ib1 & 8'hbf, ib2 & 8'hef);
    end_sim();
  end
  // watchdog well beyond the seventeen frames of the run
  initial begin
    #400us;
    err_count++;
    end_sim();
  end
endmodule : amp_diag_status_readback_tb_top
